// >>> design/cache_stat_counters.sv
// module: hit and miss statistics counters of the prefetch cache with register port
`timescale 1ns/1ps

// Notes on behaviour
// - cacheable fetch or load hit bumps hit count, except in a cycle that writes the hit counter
// - cacheable fetch miss bumps miss count, except in a cycle that writes the miss counter
// - non-cacheable accesses touch neither counter
// - hit counter: 32-bit read/write, unknown at power-on
// - miss counter: 32-bit read/write, unknown at power-on
module cache_stat_counters (
    // clock and reset
    input  wire logic                              clock_i,
    input  wire logic                              resetn_i,
    // register port
    input  wire logic [cache_stat_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [cache_stat_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                              wr_i,
    input  wire logic                              rd_i,
    output logic      [cache_stat_pkg::DATA_W-1:0] rd_data_o,
    // core access path
    input  wire cache_stat_pkg::access_t           access_i,
    // event pulses
    output logic                                   hit_event_o,
    output logic                                   miss_event_o
);

    // ************************************************************
    // declarations
    // ************************************************************
    cache_stat_pkg::bus_req_t              req;
    logic                                  sel_hit;
    logic                                  sel_miss;
    logic                                  wr_hit;
    logic                                  wr_miss;
    logic                                  count_hit;
    logic                                  count_miss;
    logic [cache_stat_pkg::DATA_W-1:0]     hit_count;
    logic [cache_stat_pkg::DATA_W-1:0]     miss_count;
    logic [cache_stat_pkg::DATA_W-1:0]     rd_data_reg;
    logic [cache_stat_pkg::DATA_W-1:0]     rd_data_next;
    logic                                  hit_event_reg;
    logic                                  hit_event_next;
    logic                                  miss_event_reg;
    logic                                  miss_event_next;

    // ************************************************************
    // bus request and address decode
    // ************************************************************
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;
    assign req.addr  = addr_i;
    assign req.wdata = wr_data_i;

    assign sel_hit  = (req.addr == cache_stat_pkg::HIT_COUNTER_OFFSET);
    assign sel_miss = (req.addr == cache_stat_pkg::MISS_COUNTER_OFFSET);
    assign wr_hit   = req.wr && sel_hit;
    assign wr_miss  = req.wr && sel_miss;

    // ************************************************************
    // access classification
    // ************************************************************
    always_comb begin
        count_hit  = 1'b0;
        count_miss = 1'b0;
        if (access_i.valid && access_i.cacheable) begin
            count_hit  = access_i.hit && (access_i.fetch || access_i.load);
            count_miss = !access_i.hit && access_i.fetch;
        end
    end

    // ************************************************************
    // counters
    // ************************************************************
    stat_counter hit_counter_inst (
        .clock_i      (clock_i),
        .load_i       (wr_hit),
        .load_value_i (req.wdata),
        .inc_i        (count_hit),
        .count_o      (hit_count)
    );

    stat_counter miss_counter_inst (
        .clock_i      (clock_i),
        .load_i       (wr_miss),
        .load_value_i (req.wdata),
        .inc_i        (count_miss),
        .count_o      (miss_count)
    );

    // ************************************************************
    // read data and event pulses, next values
    // ************************************************************
    always_comb begin
        rd_data_next    = cache_stat_pkg::READ_IDLE_VALUE;
        hit_event_next  = count_hit;
        miss_event_next = count_miss;
        if (req.rd) begin
            if (sel_hit) begin
                rd_data_next = hit_count;
            end else if (sel_miss) begin
                rd_data_next = miss_count;
            end else begin
                rd_data_next = cache_stat_pkg::UNMAPPED_VALUE;
            end
        end
    end

    // ************************************************************
    // read data and event pulses, registers
    // ************************************************************
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_reg    <= cache_stat_pkg::READ_IDLE_VALUE;
            hit_event_reg  <= 1'b0;
            miss_event_reg <= 1'b0;
        end else begin
            rd_data_reg    <= rd_data_next;
            hit_event_reg  <= hit_event_next;
            miss_event_reg <= miss_event_next;
        end
    end

    assign rd_data_o    = rd_data_reg;
    assign hit_event_o  = hit_event_reg;
    assign miss_event_o = miss_event_reg;

endmodule : cache_stat_counters

// >>> design/cache_stat_pkg.sv
// package: register map, bus widths and access carrier for the cache statistics counters
package cache_stat_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ************************************************************
    // register offsets (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [ADDR_W-1:0] HIT_COUNTER_OFFSET  = 8'h00;
    localparam logic [ADDR_W-1:0] MISS_COUNTER_OFFSET = 8'h04;

    // ************************************************************
    // values
    // ************************************************************
    localparam logic [DATA_W-1:0] READ_IDLE_VALUE = 32'h00000000;
    localparam logic [DATA_W-1:0] UNMAPPED_VALUE  = 32'h00000000;
    localparam logic [DATA_W-1:0] COUNT_STEP      = 32'h00000001;

    // ************************************************************
    // one access from the core fetch and load path
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic fetch;
        logic load;
        logic cacheable;
        logic hit;
    } access_t;

    // ************************************************************
    // register bus request
    // ************************************************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage : cache_stat_pkg

// >>> design/stat_counter.sv
// module: one loadable wrapping statistics counter
`timescale 1ns/1ps

module stat_counter (
    // clock
    input  wire logic                              clock_i,
    // control
    input  wire logic                              load_i,
    input  wire logic [cache_stat_pkg::DATA_W-1:0] load_value_i,
    input  wire logic                              inc_i,
    // state
    output logic      [cache_stat_pkg::DATA_W-1:0] count_o
);

    logic [cache_stat_pkg::DATA_W-1:0] count_reg;
    logic [cache_stat_pkg::DATA_W-1:0] count_next;

    // ************************************************************
    // next value
    // ************************************************************
    always_comb begin
        count_next = count_reg;
        if (load_i) begin
            count_next = load_value_i;
        end else if (inc_i) begin
            count_next = count_reg + cache_stat_pkg::COUNT_STEP;
        end
    end

    // ************************************************************
    // storage, no reset: value unknown until software loads it
    // ************************************************************
    always_ff @(posedge clock_i) begin
        count_reg <= count_next;
    end

    assign count_o = count_reg;

endmodule : stat_counter

// >>> sim/cache_stat_counters_props.sv
// checker: event pulses and read data of the cache statistics counters
`timescale 1ns/1ps
module cache_stat_counters_props (
    input wire logic                              clock_i,
    input wire logic                              resetn_i,
    input wire logic [cache_stat_pkg::ADDR_W-1:0] addr_i,
    input wire logic [cache_stat_pkg::DATA_W-1:0] wr_data_i,
    input wire logic                              wr_i,
    input wire logic                              rd_i,
    input wire logic [cache_stat_pkg::DATA_W-1:0] rd_data_o,
    input wire cache_stat_pkg::access_t           access_i,
    input wire logic                              hit_event_o,
    input wire logic                              miss_event_o
);
    logic hit_in;
    logic miss_in;
    assign hit_in  = access_i.valid && access_i.cacheable && access_i.hit && (access_i.fetch || access_i.load);
    assign miss_in = access_i.valid && access_i.cacheable && access_i.fetch && !access_i.hit;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    hit_pulse_a: assert property (hit_in && !wr_i |=> hit_event_o) else $error("hit pulse missing");
    miss_pulse_a: assert property (miss_in && !wr_i |=> miss_event_o) else $error("miss pulse missing");
    hit_cause_a: assert property (hit_event_o |-> $past(hit_in)) else $error("hit pulse without cause");
    miss_cause_a: assert property (miss_event_o |-> $past(miss_in)) else $error("miss pulse without cause");
    read_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h00000000) else $error("read data not idle");
    unmapped_read_a: assert property (rd_i && addr_i[7:3] != 5'h00 |=> rd_data_o == 32'h00000000)
        else $error("unmapped read not zero");
    reload_read_a: assert property ((wr_i && addr_i == 8'h00 && !access_i.valid) ##1 (rd_i && addr_i == 8'h00
        && !access_i.valid) |=> rd_data_o == $past(wr_data_i, 2)) else $error("written value not read");
endmodule : cache_stat_counters_props

bind cache_stat_counters cache_stat_counters_props i_props (.clock_i(clock_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .access_i(access_i), .hit_event_o(hit_event_o), .miss_event_o(miss_event_o));

// >>> sim/cache_stat_counters_tb.sv
// testbench: register access and hit and miss counting
`timescale 1ns/1ps
module cache_stat_counters_tb;
    logic                    clock_i   = 1'b0;
    logic                    resetn_i  = 1'b0;
    logic [7:0]              addr_i    = 8'h00;
    logic [31:0]             wr_data_i = 32'h00000000;
    logic                    wr_i      = 1'b0;
    logic                    rd_i      = 1'b0;
    logic [31:0]             rd_data_o;
    cache_stat_pkg::access_t access_i;
    logic                    hit_event_o;
    logic                    miss_event_o;
    int                      fail_count  = 0;
    int                      check_count = 0;
    int                      cycles      = 0;
    logic [31:0]             exp_hit;
    logic [31:0]             exp_miss;
    logic [31:0]             hit_pulses  = 32'h00000000;
    logic [31:0]             miss_pulses = 32'h00000000;
    logic [3:0]              kinds [7] = '{4'hB, 4'h7, 4'hA, 4'h6, 4'h9, 4'h8, 4'h5};
    cache_stat_counters i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .access_i(access_i), .hit_event_o(hit_event_o),
        .miss_event_o(miss_event_o));
    core_access_model i_core (.clock_i(clock_i), .access_o(access_i));
    initial forever #2 clock_i = ~clock_i;
    always @(negedge clock_i) begin
        if (hit_event_o === 1'b1) begin
            hit_pulses <= hit_pulses + 32'h00000001;
        end
        if (miss_event_o === 1'b1) begin
            miss_pulses <= miss_pulses + 32'h00000001;
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        {wr_i, rd_i, addr_i, wr_data_i} <= {w, r, a, d};
        @(posedge clock_i);
    endtask : bus
    task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check32
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, 1'b1, a, 32'h00000000);
        {wr_i, rd_i} <= 2'b00;
        #1;
        check32(name, exp, rd_data_o);
        @(posedge clock_i);
    endtask : rd
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        bus(1'b1, 1'b0, 8'h00, 32'hFFFFFFFE);
        bus(1'b1, 1'b0, 8'h04, 32'h00000010);
        bus(1'b1, 1'b0, 8'h08, 32'h12345678);
        rd(8'h08, 32'h00000000, "unmapped");
        rd(8'h00, 32'hFFFFFFFE, "hit_rw");
        rd(8'h04, 32'h00000010, "miss_rw");
        exp_hit = 32'hFFFFFFFE;
        exp_miss = 32'h00000010;
        foreach (kinds[k]) begin
            i_core.issue({1'b1, kinds[k]});
            exp_hit = exp_hit + 32'(kinds[k][1] & kinds[k][0] & (kinds[k][3] | kinds[k][2]));
            exp_miss = exp_miss + 32'(kinds[k][1] & kinds[k][3] & !kinds[k][0]);
        end
        i_core.issue(5'h00);
        rd(8'h00, exp_hit, "hit_count");
        rd(8'h04, exp_miss, "miss_count");
        check32("hit_pulses", exp_hit - 32'hFFFFFFFE, hit_pulses);
        check32("miss_pulses", exp_miss - 32'h00000010, miss_pulses);
        bus(1'b1, 1'b0, 8'h00, 32'hA5A5A5A5);
        rd(8'h00, 32'hA5A5A5A5, "reload");
        summarize();
    end
endmodule : cache_stat_counters_tb

// >>> sim/core_access_model.sv
// model: core fetch and load path issuing one access a cycle
`timescale 1ns/1ps
module core_access_model (
    input  wire logic              clock_i,
    output cache_stat_pkg::access_t access_o
);
    initial access_o = 5'h00;
    task automatic issue(input logic [4:0] acc);
        access_o <= acc;
        @(posedge clock_i);
    endtask : issue
endmodule : core_access_model
